// ---- src/dbse_map.svh ----
`ifndef DBSE_MAP_SVH
`define DBSE_MAP_SVH
// =====================================================================
// Widths and table depth
`define DBSE_DATA_W 8
`define DBSE_STATE_W 8
`define DBSE_OFS_W 8
`define DBSE_TBL_DEPTH 256
`define DBSE_CNT_W 9
// =====================================================================
// Reset values
`define DBSE_PREV_RST 1'b0
`define DBSE_STATE_RST 8'h00
`define DBSE_NUM_STATES_RST 9'h004
`define DBSE_TBL_SIZE_RST 9'h004
`endif

// ---- src/dbse_pkg.sv ----
`include "dbse_map.svh"
package dbse_pkg;
  typedef enum logic [1:0] {
    DBSE_ST_FIRST = 2'b01,
    DBSE_ST_RUN = 2'b10
  } dbse_bit_st_t;
  typedef logic [`DBSE_STATE_W-1:0] dbse_state_t;
  typedef logic signed [`DBSE_OFS_W-1:0] dbse_ofs_t;
endpackage

// ---- src/dbse_ofs_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbse_map.svh"
module dbse_ofs_mem
(
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [`DBSE_DATA_W-1:0] i_waddr,
  input wire logic [`DBSE_OFS_W-1:0] i_wdata,
  // Read port
  input wire logic [`DBSE_DATA_W-1:0] i_raddr,
  output logic [`DBSE_OFS_W-1:0] o_rdata
);
  logic [`DBSE_OFS_W-1:0] mem [`DBSE_TBL_DEPTH];
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// ---- src/dbse_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbse_map.svh"
module dbse_top
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Configuration
  input wire logic i_bit_enc_en,
  input wire logic i_sym_enc_en,
  input wire logic [`DBSE_CNT_W-1:0] i_num_states,
  input wire logic [`DBSE_CNT_W-1:0] i_tbl_size,
  // Offset table write
  input wire logic i_tbl_we,
  input wire logic [`DBSE_DATA_W-1:0] i_tbl_addr,
  input wire logic [`DBSE_OFS_W-1:0] i_tbl_ofs,
  // Serial bit stream
  input wire logic i_bit_valid,
  input wire logic i_bit,
  output logic o_bit_valid,
  output logic o_bit,
  // Symbol stream
  input wire logic i_sym_valid,
  input wire logic [`DBSE_DATA_W-1:0] i_sym,
  output logic o_sym_valid,
  output logic [`DBSE_STATE_W-1:0] o_state,
  output logic [3:0] o_bits_per_sym,
  output logic signed [1:0] o_i_def,
  output logic signed [1:0] o_q_def
);
  // ===================================================================
  // Bit-level encoder
  dbse_pkg::dbse_bit_st_t bst, next_bst;
  logic prev_bit, next_prev_bit;
  logic next_o_bit_valid, next_o_bit;
  always_comb
  begin
    next_bst = bst;
    next_prev_bit = prev_bit;
    next_o_bit_valid = 1'b0;
    next_o_bit = o_bit;
    if (i_bit_valid)
    begin
      next_prev_bit = i_bit;
      if (!i_bit_enc_en)
      begin
        next_o_bit_valid = 1'b1;
        next_o_bit = i_bit;
      end
      else
      begin
        case (bst)
          dbse_pkg::DBSE_ST_FIRST:
          begin
            next_bst = dbse_pkg::DBSE_ST_RUN;
          end
          dbse_pkg::DBSE_ST_RUN:
          begin
            next_o_bit_valid = 1'b1;
            next_o_bit = i_bit ^ prev_bit;
          end
          default:
          begin
            next_bst = dbse_pkg::DBSE_ST_FIRST;
          end
        endcase
      end
    end
    if (!i_bit_enc_en)
    begin
      next_bst = dbse_pkg::DBSE_ST_FIRST;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      bst <= dbse_pkg::DBSE_ST_FIRST;
      prev_bit <= `DBSE_PREV_RST;
      o_bit_valid <= 1'b0;
      o_bit <= 1'b0;
    end
    else
    begin
      bst <= next_bst;
      prev_bit <= next_prev_bit;
      o_bit_valid <= next_o_bit_valid;
      o_bit <= next_o_bit;
    end
  end
  // ===================================================================
  // Bits per symbol and data masking
  logic [3:0] bps;
  logic [`DBSE_DATA_W-1:0] sym_mask;
  always_comb
  begin
    bps = 4'h0;
    for (int k = 0; k < 9; k++)
    begin
      if ((9'h001 << k) < i_tbl_size)
      begin
        bps = 4'(k + 1);
      end
    end
    if (bps > 4'h8)
    begin
      sym_mask = 8'hff;
    end
    else
    begin
      sym_mask = 8'((9'h001 << bps) - 9'h001);
    end
  end
  // ===================================================================
  // Offset table
  logic [`DBSE_OFS_W-1:0] ofs_raw;
  dbse_ofs_mem u_mem
  (
    .i_clk(i_clk),
    .i_we(i_tbl_we),
    .i_waddr(i_tbl_addr),
    .i_wdata(i_tbl_ofs),
    .i_raddr(i_sym & sym_mask),
    .o_rdata(ofs_raw)
  );
  // ===================================================================
  // Symbol-level state walker
  logic sym_p1, next_sym_p1;
  dbse_pkg::dbse_state_t state, next_state;
  logic next_o_sym_valid;
  logic [3:0] next_bps;
  logic signed [1:0] next_i_def, next_q_def;
  logic signed [9:0] ofs_mod, sum;
  logic [9:0] nst;
  always_comb
  begin
    next_sym_p1 = i_sym_valid;
    next_state = state;
    next_o_sym_valid = 1'b0;
    next_bps = bps;
    nst = (i_num_states == 9'h000) ? 10'h001 : {1'b0, i_num_states};
    ofs_mod = 10'(signed'(ofs_raw)) % signed'(nst);
    sum = signed'({2'b00, state}) + ofs_mod;
    if (sum < 0)
    begin
      sum = sum + signed'(nst);
    end
    else if (sum >= signed'(nst))
    begin
      sum = sum - signed'(nst);
    end
    if (sym_p1)
    begin
      next_o_sym_valid = 1'b1;
      if (i_sym_enc_en)
      begin
        next_state = 8'(sum);
      end
    end
    next_i_def = next_state[1] ? -2'sd1 : 2'sd1;
    next_q_def = next_state[0] ? -2'sd1 : 2'sd1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sym_p1 <= 1'b0;
      state <= `DBSE_STATE_RST;
      o_sym_valid <= 1'b0;
      o_bits_per_sym <= 4'h0;
      o_i_def <= 2'sd1;
      o_q_def <= 2'sd1;
    end
    else
    begin
      sym_p1 <= next_sym_p1;
      state <= next_state;
      o_sym_valid <= next_o_sym_valid;
      o_bits_per_sym <= next_bps;
      o_i_def <= next_i_def;
      o_q_def <= next_q_def;
    end
  end
  assign o_state = state;
  // ===================================================================
  // Assertions
  a_bit_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bit_valid && !i_bit_enc_en) |=> (o_bit_valid && o_bit == $past(i_bit)))
    else $error("raw bit not passed");
  a_bit_xor: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bit_valid && i_bit_enc_en && bst == dbse_pkg::DBSE_ST_RUN)
    |=> (o_bit == ($past(i_bit) ^ $past(prev_bit))))
    else $error("xor wrong");
  a_first_drop: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bit_valid && i_bit_enc_en && bst == dbse_pkg::DBSE_ST_FIRST)
    |=> !o_bit_valid)
    else $error("first bit emitted");
  a_state_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (!sym_p1 || !i_sym_enc_en) |=> $stable(state))
    else $error("state moved idle");
  a_state_range: assert property (@(posedge i_clk)
    disable iff (i_srst)
    (i_num_states != 9'h000 && $stable(i_num_states))
    |=> ({1'b0, state} < i_num_states || $past(state) == state))
    else $error("state out of range");
  a_sym_lat: assert property (@(posedge i_clk) disable iff (i_srst)
    i_sym_valid |-> ##2 o_sym_valid)
    else $error("symbol latency");
  a_zero_ofs: assert property (@(posedge i_clk) disable iff (i_srst)
    (sym_p1 && i_sym_enc_en && ofs_raw == 8'h00) |=> $stable(state))
    else $error("zero offset moved");
  a_rst_state: assert property (@(posedge i_clk)
    i_srst |=> (state == 8'h00 && prev_bit == 1'b0))
    else $error("reset state");
endmodule
`default_nettype wire

// ---- verif/dbse_mapper_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbse_map.svh"
// =====================================================================
// Downstream mapper sink: logs every encoded bit and symbol state
module dbse_mapper_model
(
  // Clock
  input wire logic i_clk,
  // Encoded streams
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_sym_valid,
  input wire logic [`DBSE_STATE_W-1:0] i_state
);
  logic [31:0] bit_log = 32'h0;
  int bit_cnt = 0;
  logic [`DBSE_STATE_W-1:0] sym_log [0:15];
  int sym_cnt = 0;
  always @(posedge i_clk)
  begin
    if (i_bit_valid)
    begin
      bit_log = {bit_log[30:0], i_bit};
      bit_cnt++;
    end
    if (i_sym_valid)
    begin
      sym_log[sym_cnt % 16] = i_state;
      sym_cnt++;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbse_map.svh"
// =====================================================================
// Bench for the differential bit and symbol encoder
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic bit_en = 1'b0;
  logic sym_en = 1'b0;
  logic [8:0] n_st = `DBSE_NUM_STATES_RST;
  logic [8:0] t_sz = `DBSE_TBL_SIZE_RST;
  logic we = 1'b0;
  logic [7:0] ta = 8'h00;
  logic [7:0] tof = 8'h00;
  logic bv = 1'b0;
  logic bi = 1'b0;
  logic sv = 1'b0;
  logic [7:0] si = 8'h00;
  logic obv, ob, osv;
  logic [7:0] st;
  logic [3:0] bps;
  logic signed [1:0] idf, qdf;
  logic [7:0] exp_st [5] = '{8'h01, 8'h01, 8'h03, 8'h00, 8'h03};
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int n0;
  dbse_top i_dut (.i_clk(clk), .i_srst(srst), .i_bit_enc_en(bit_en),
    .i_sym_enc_en(sym_en), .i_num_states(n_st), .i_tbl_size(t_sz),
    .i_tbl_we(we), .i_tbl_addr(ta), .i_tbl_ofs(tof), .i_bit_valid(bv),
    .i_bit(bi), .o_bit_valid(obv), .o_bit(ob), .i_sym_valid(sv),
    .i_sym(si), .o_sym_valid(osv), .o_state(st), .o_bits_per_sym(bps),
    .o_i_def(idf), .o_q_def(qdf));
  dbse_mapper_model i_model (.i_clk(clk), .i_bit_valid(obv), .i_bit(ob),
    .i_sym_valid(osv), .i_state(st));
  // =====================================================================
  // Checking and access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle;
    we = 1'b0;
    bv = 1'b0;
    sv = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Bits go back to back, oldest at the msb
  task automatic send_bits(input logic [15:0] v, input int n);
    n0 = i_model.bit_cnt;
    for (int k = n - 1; k >= 0; k--)
    begin
      bv = 1'b1;
      bi = v[k];
      @(negedge clk);
    end
    idle();
  endtask
  task automatic sym(input logic [7:0] d);
    sv = 1'b1;
    si = d;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] o);
    we = 1'b1;
    ta = a;
    tof = o;
    @(negedge clk);
  endtask
  // =====================================================================
  // Clock, timeout and test sequence
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk(st, 16'h0000);
    chk({12'h000, idf, qdf}, 16'h0005);
    send_bits(16'h000b, 4);
    chk(i_model.bit_cnt - n0, 16'h0004);
    chk(i_model.bit_log[3:0], 16'h000b);
    bit_en = 1'b1;
    @(negedge clk);
    send_bits(16'h14ca, 14);
    chk(i_model.bit_cnt - n0, 16'h000d);
    chk(i_model.bit_log[12:0], 16'h1eaf);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'hff);
    wr(8'h02, 8'h02);
    wr(8'h03, 8'h00);
    sym_en = 1'b1;
    idle();
    n0 = i_model.sym_cnt;
    sym(8'h00);
    sym(8'h03);
    sym(8'h02);
    sym(8'h00);
    sym(8'h01);
    idle();
    chk(i_model.sym_cnt - n0, 16'h0005);
    for (int k = 0; k < 5; k++)
      chk(i_model.sym_log[(n0+k)%16], exp_st[k]);
    chk(bps, 16'h0002);
    chk({12'h000, idf, qdf}, 16'h000f);
    sym_en = 1'b0;
    sym(8'h01);
    idle();
    chk(st, 16'h0003);
    t_sz = 9'h002;
    sym_en = 1'b1;
    sym(8'h02);
    idle();
    chk(st, 16'h0000);
    chk(bps, 16'h0001);
    sym(8'h03);
    idle();
    chk(st, 16'h0003);
    t_sz = 9'h005;
    repeat (2) @(negedge clk);
    chk(bps, 16'h0003);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk(st, 16'h0000);
    send_bits(16'h0002, 2);
    chk(i_model.bit_cnt - n0, 16'h0001);
    chk(i_model.bit_log[0], 16'h0001);
    // Three-state map: wrap past either end with a modulus not a power of two
    n_st = 9'h003;
    t_sz = `DBSE_TBL_SIZE_RST;
    n0 = i_model.sym_cnt;
    sym(8'h02);
    sym(8'h02);
    sym(8'h01);
    sym(8'h01);
    idle();
    chk(i_model.sym_cnt - n0, 16'h0004);
    chk(i_model.sym_log[n0 % 16], 16'h0002);
    chk(i_model.sym_log[(n0+1)%16], 16'h0001);
    chk(i_model.sym_log[(n0+2)%16], 16'h0000);
    chk(st, 16'h0002);
    give_verdict();
  end
endmodule
`default_nettype wire
